// ===== rtl/aimto_defines.vh
// constants for the converter input mux and temperature offset block
`ifndef AIMTO_DEFINES_VH
`define AIMTO_DEFINES_VH
`define AIMTO_PAGE_MAIN     4'h0
`define AIMTO_PAGE_CFG      4'hF
`define AIMTO_ADDR_SEL      8'hBB
`define AIMTO_ADDR_OFFL     8'h85
`define AIMTO_ADDR_OFFH     8'h86
`define AIMTO_SEL_RESET     5'h1F
`define AIMTO_SEL_P0_LAST   5'h07
`define AIMTO_SEL_P1_FIRST  5'h0D
`define AIMTO_SEL_P1_LAST   5'h0F
`define AIMTO_SEL_P2_FIRST  5'h10
`define AIMTO_SEL_P2_LAST   5'h16
`define AIMTO_SEL_TEMP      5'h1B
`define AIMTO_SEL_VDD_A     5'h1C
`define AIMTO_SEL_VREG      5'h1D
`define AIMTO_SEL_VDD_B     5'h1E
`define AIMTO_SEL_GND       5'h1F
`define AIMTO_SRC_NONE      3'h0
`define AIMTO_SRC_PORT      3'h1
`define AIMTO_SRC_TEMP      3'h2
`define AIMTO_SRC_SUPPLY    3'h3
`define AIMTO_SRC_DREG      3'h4
`define AIMTO_SRC_GND       3'h5
`define AIMTO_SEL_MSB       4
`define AIMTO_SEL_LSB       0
`define AIMTO_SEL_PAD       3'h0
`define AIMTO_REG_BITS      8
`define AIMTO_OFFL_KEEP     2
`define AIMTO_OFFL_PAD      6'h00
`define AIMTO_RDATA_IDLE    8'h00
`define AIMTO_HIT_SEL       3'h4
`define AIMTO_HIT_OFFH      3'h2
`define AIMTO_HIT_OFFL      3'h1
`define AIMTO_PIN_P0_BASE   5'h00
`define AIMTO_PIN_P1_BASE   5'h08
`define AIMTO_PIN_P2_BASE   5'h0B
`define AIMTO_PINS_NONE     23'h000000
`define AIMTO_PIN_FIRST     23'h000001
`define AIMTO_HIZ_RESET     1'b1
`endif

// ===== rtl/aimto_mux_ctrl.v
// input channel select register, mux decode and factory offset readout
`timescale 1ns/10ps
`default_nettype none
`include "aimto_defines.vh"

// Behaviour
// R01 - decode five-bit select into port pin, sensor, supply, regulator, ground or reserved
// R02 - software selects ground before moving to the sensor channel
// R03 - software selects sensor channel to measure temperature, single-ended only
// R04 - sensor output high impedance while sensor enable bit is clear
// R05 - offset high register reads offset bits 9 to 2
// R06 - offset low register reads offset bits 1 and 0 at positions 7 and 6
// R07 - offset low bits 5 to 0 read zero, writes ignored
// R08 - offset registers hold per-device trimmed value, not a reset constant
// R09 - select register at page 0 address BB, upper three bits read zero
// R10 - writes to offset registers change nothing
module aimto_mux_ctrl #(
    parameter OFFSET_WIDTH = 10
) (
    input  wire                    core_clk,        // system clock, 250 MHz
    input  wire                    arst_n,          // async reset, active low
    input  wire [3:0]              sfrPage,         // current register page
    input  wire [7:0]              sfrAddr,         // register address
    input  wire                    sfrWr,           // write strobe
    input  wire                    sfrRd,           // read strobe
    input  wire [7:0]              sfrWdata,        // write data
    input  wire [OFFSET_WIDTH-1:0] factoryOffset,   // production-test offset value
    input  wire                    tempSensorEnable,// sensor enable from reference control
    output reg  [7:0]              sfrRdata,        // registered read data
    output reg                     sfrRdValid,      // read data valid pulse
    output reg  [4:0]              positiveInputSelect, // select code to analog mux
    output reg  [22:0]             portPinSelect,   // one-hot pin switch, P0 0-7,P1 5-7,P2 0-6
    output reg  [2:0]              muxSource,       // decoded source class
    output reg                     channelReserved, // select holds a reserved code
    output reg                     tempSensorHiZ    // sensor output floating
);

    ////////////////////////////////////////////////////////////////////////
    reg        rstMeta_q;
    reg        rstSync_q;
    wire       rstN = rstSync_q;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register decode; page and address must both match
    wire       hitSel;
    wire       hitOffL;
    wire       hitOffH;
    wire       selWrite;

    assign hitSel   = (sfrPage == `AIMTO_PAGE_MAIN) && (sfrAddr == `AIMTO_ADDR_SEL);
    assign hitOffL  = (sfrPage == `AIMTO_PAGE_CFG) && (sfrAddr == `AIMTO_ADDR_OFFL);
    assign hitOffH  = (sfrPage == `AIMTO_PAGE_CFG) && (sfrAddr == `AIMTO_ADDR_OFFH);
    // R10 offset pages get no write path
    assign selWrite = sfrWr && hitSel;

    ////////////////////////////////////////////////////////////////////////
    reg [4:0] sel_q;
    reg [4:0] sel_d;

    always @* begin
        sel_d = sel_q;
        // R09 select register write
        if (selWrite) begin
            // bits 7 to 5 have no storage
            sel_d = sfrWdata[`AIMTO_SEL_MSB:`AIMTO_SEL_LSB];
        end
    end

    // R09 select holds ground after reset
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sel_q <= `AIMTO_SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset is wired from trim storage, so it varies per part and has no reset value
    wire [7:0] selReadback;
    wire [7:0] offHighReadback;
    wire [7:0] offLowReadback;
    reg  [7:0] rdata_d;

    // R09 upper bits zero
    assign selReadback     = {`AIMTO_SEL_PAD, sel_q};
    // R05 R08 offset high
    assign offHighReadback = factoryOffset[OFFSET_WIDTH-1:OFFSET_WIDTH-`AIMTO_REG_BITS];
    // R06 R07 offset low
    assign offLowReadback  = {factoryOffset[`AIMTO_OFFL_KEEP-1:0], `AIMTO_OFFL_PAD};

    always @* begin
        rdata_d = `AIMTO_RDATA_IDLE;
        case ({hitSel, hitOffH, hitOffL})
            `AIMTO_HIT_SEL: begin
                rdata_d = selReadback;
            end
            `AIMTO_HIT_OFFH: begin
                rdata_d = offHighReadback;
            end
            `AIMTO_HIT_OFFL: begin
                rdata_d = offLowReadback;
            end
            default: begin
                // unmapped addresses read back zero
                rdata_d = `AIMTO_RDATA_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sfrRdata   <= `AIMTO_RDATA_IDLE;
            sfrRdValid <= 1'b0;
        end else begin
            // bus idles at zero so it can be or-ed with other sources
            sfrRdata   <= sfrRd ? rdata_d : `AIMTO_RDATA_IDLE;
            sfrRdValid <= sfrRd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    reg        pinValid_d;
    reg [4:0]  pinIndex_d;
    reg [22:0] pins_d;
    reg [2:0]  src_d;
    reg        reserved_d;

    // R01 port pin ranges
    always @* begin
        pinValid_d = 1'b0;
        pinIndex_d = `AIMTO_PIN_P0_BASE;
        if (sel_d <= `AIMTO_SEL_P0_LAST) begin
            pinValid_d = 1'b1;
            pinIndex_d = sel_d + `AIMTO_PIN_P0_BASE;
        end else if ((sel_d >= `AIMTO_SEL_P1_FIRST) && (sel_d <= `AIMTO_SEL_P1_LAST)) begin
            pinValid_d = 1'b1;
            pinIndex_d = sel_d - `AIMTO_SEL_P1_FIRST + `AIMTO_PIN_P1_BASE;
        end else if ((sel_d >= `AIMTO_SEL_P2_FIRST) && (sel_d <= `AIMTO_SEL_P2_LAST)) begin
            pinValid_d = 1'b1;
            pinIndex_d = sel_d - `AIMTO_SEL_P2_FIRST + `AIMTO_PIN_P2_BASE;
        end
    end

    // one shifter instead of a comparator per pin
    always @* begin
        pins_d = `AIMTO_PINS_NONE;
        if (pinValid_d) begin
            pins_d = `AIMTO_PIN_FIRST << pinIndex_d;
        end
    end

    // R01 channel class decode
    always @* begin
        src_d = `AIMTO_SRC_NONE;
        case (sel_d)
            `AIMTO_SEL_TEMP: begin
                src_d = `AIMTO_SRC_TEMP;
            end
            `AIMTO_SEL_VDD_A: begin
                src_d = `AIMTO_SRC_SUPPLY;
            end
            `AIMTO_SEL_VREG: begin
                src_d = `AIMTO_SRC_DREG;
            end
            `AIMTO_SEL_VDD_B: begin
                src_d = `AIMTO_SRC_SUPPLY;
            end
            `AIMTO_SEL_GND: begin
                src_d = `AIMTO_SRC_GND;
            end
            default: begin
                if (pinValid_d) begin
                    src_d = `AIMTO_SRC_PORT;
                end
            end
        endcase
    end

    // R01 reserved codes stored, nothing switched in
    always @* begin
        reserved_d = (src_d == `AIMTO_SRC_NONE);
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs follow the register's next value so they land with the write
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            positiveInputSelect <= `AIMTO_SEL_RESET;
            portPinSelect       <= `AIMTO_PINS_NONE;
            muxSource           <= `AIMTO_SRC_GND;
            channelReserved     <= 1'b0;
        end else begin
            positiveInputSelect <= sel_d;
            portPinSelect       <= pins_d;
            muxSource           <= src_d;
            channelReserved     <= reserved_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ground-before-sensor sequencing is left to software; the mux
    // switches straight to whatever code is written
    // R04 sensor floats
    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            tempSensorHiZ <= `AIMTO_HIZ_RESET;
        end else begin
            tempSensorHiZ <= ~tempSensorEnable;
        end
    end

endmodule
`default_nettype wire

// ===== verif/aimto_mux_ctrl_checker.sv
// assertions on the input select and offset readout ports
`timescale 1ns/10ps
`default_nettype none
module aimto_mux_ctrl_checker #(
    parameter OFFSET_WIDTH = 10
) (
    input wire logic                    core_clk, arst_n, sfrWr, sfrRd, tempSensorEnable,
    input wire logic [3:0]              sfrPage,
    input wire logic [7:0]              sfrAddr, sfrWdata, sfrRdata,
    input wire logic [OFFSET_WIDTH-1:0] factoryOffset,
    input wire logic                    sfrRdValid, channelReserved, tempSensorHiZ,
    input wire logic [4:0]              positiveInputSelect,
    input wire logic [22:0]             portPinSelect,
    input wire logic [2:0]              muxSource
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic selAt = sfrPage == 4'h0 && sfrAddr == 8'hBB;
    wire logic hiAt  = sfrPage == 4'hF && sfrAddr == 8'h86;
    wire logic loAt  = sfrPage == 4'hF && sfrAddr == 8'h85;
    property p_offh; sfrRd && hiAt |=> sfrRdValid && sfrRdata == $past(factoryOffset[9:2]); endproperty
    a_offh: assert property (p_offh) else $error("offset high readback");
    property p_offl; sfrRd && loAt |=> sfrRdata == {$past(factoryOffset[1:0]), 6'h00}; endproperty
    a_offl: assert property (p_offl) else $error("offset low readback");
    property p_selrd; sfrRd && selAt |=> sfrRdata == {3'h0, $past(positiveInputSelect)}; endproperty
    a_selrd: assert property (p_selrd) else $error("select readback");
    property p_selwr; sfrWr && selAt |=> {3'h0, positiveInputSelect} == ($past(sfrWdata) & 8'h1F); endproperty
    a_selwr: assert property (p_selwr) else $error("select write");
    property p_temp; positiveInputSelect == 5'h1B |-> muxSource == 3'h2 && portPinSelect == 23'h0; endproperty
    a_temp: assert property (p_temp) else $error("sensor channel decode");
    property p_pins; positiveInputSelect <= 5'h07 |-> portPinSelect == 23'h1 << positiveInputSelect; endproperty
    a_pins: assert property (p_pins) else $error("port pin decode");
    property p_hiz; 1'b1 |=> tempSensorHiZ == !$past(tempSensorEnable); endproperty
    a_hiz: assert property (p_hiz) else $error("sensor not floating");
    property p_offwr; sfrWr && (hiAt || loAt) |=> $stable(positiveInputSelect); endproperty
    a_offwr: assert property (p_offwr) else $error("offset write disturbed select");
endmodule
bind aimto_mux_ctrl aimto_mux_ctrl_checker #(.OFFSET_WIDTH(OFFSET_WIDTH)) i_chk (
    .core_clk(core_clk), .arst_n(arst_n), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .tempSensorEnable(tempSensorEnable), .sfrPage(sfrPage), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .factoryOffset(factoryOffset),
    .sfrRdValid(sfrRdValid), .channelReserved(channelReserved), .tempSensorHiZ(tempSensorHiZ),
    .positiveInputSelect(positiveInputSelect), .portPinSelect(portPinSelect),
    .muxSource(muxSource)
);
`default_nettype wire

// ===== verif/aimto_mux_ctrl_tb.sv
// self-checking bench for the input select and offset readout
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: %h not %h", $time, a, e); end end
module aimto_mux_ctrl_tb;
    logic        core_clk = 0, arst_n = 0, sfrWr = 0, sfrRd = 0, tempSensorEnable = 0;
    logic [3:0]  sfrPage = 4'h0;
    logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00;
    logic [9:0]  factoryOffset = 10'h2B5;
    wire  [7:0]  sfrRdata;
    wire  [22:0] portPinSelect;
    wire  [4:0]  positiveInputSelect;
    wire  [2:0]  muxSource;
    wire         sfrRdValid, channelReserved, tempSensorHiZ;
    int          n_fail = 0, n_compared = 0, cycles = 0;
    logic [4:0]  codes [14] = '{5'h00, 5'h07, 5'h0D, 5'h0F, 5'h10, 5'h16, 5'h1B,
                                5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h08, 5'h17, 5'h1A};
    logic [2:0]  srcs [14] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2,
                               3'h3, 3'h4, 3'h3, 3'h5, 3'h0, 3'h0, 3'h0};
    always #2 core_clk = ~core_clk;
    aimto_mux_ctrl i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .sfrPage(sfrPage), .sfrAddr(sfrAddr),
        .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .factoryOffset(factoryOffset),
        .tempSensorEnable(tempSensorEnable), .sfrRdata(sfrRdata), .sfrRdValid(sfrRdValid),
        .positiveInputSelect(positiveInputSelect), .portPinSelect(portPinSelect),
        .muxSource(muxSource), .channelReserved(channelReserved), .tempSensorHiZ(tempSensorHiZ)
    );
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic wr(input logic [3:0] pg, input logic [7:0] ad, dt);
        @(negedge core_clk);
        {sfrPage, sfrAddr, sfrWdata, sfrWr} = {pg, ad, dt, 1'b1};
        @(negedge core_clk);
        sfrWr = 0;
    endtask
    task automatic rd(input logic [3:0] pg, input logic [7:0] ad, ex);
        @(negedge core_clk);
        {sfrPage, sfrAddr, sfrRd} = {pg, ad, 1'b1};
        @(negedge core_clk);
        sfrRd = 0;
        `CHK(sfrRdValid, 1'b1)
        `CHK(sfrRdata, ex)
    endtask
    task automatic complete_run();
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1;
        repeat (3) @(negedge core_clk);
        rd(4'h0, 8'hBB, 8'h1F);
        `CHK(tempSensorHiZ, 1'b1)
        `CHK(muxSource, 3'h5)
        `CHK(channelReserved, 1'b0)
        `CHK(portPinSelect, 23'h0)
        // upper bits written as ones must read back zero
        for (int i = 0; i < 14; i++) begin
            wr(4'h0, 8'hBB, {3'h7, codes[i]});
            `CHK(muxSource, srcs[i])
            `CHK(channelReserved, srcs[i] == 3'h0)
            `CHK(portPinSelect, (srcs[i] == 3'h1) ? 23'h1 << (codes[i] < 5'h08 ? codes[i] : codes[i] - 5'h05) : 23'h0)
            rd(4'h0, 8'hBB, {3'h0, codes[i]});
        end
        $display("select decode test done");
        wr(4'h0, 8'hBB, 8'h1F);
        wr(4'h0, 8'hBB, 8'h1B);
        tempSensorEnable = 1;
        @(negedge core_clk);
        `CHK(tempSensorHiZ, 1'b0)
        $display("sensor channel test done");
        rd(4'hF, 8'h86, 8'hAD);
        rd(4'hF, 8'h85, 8'h40);
        wr(4'hF, 8'h86, 8'hFF);
        wr(4'hF, 8'h85, 8'hFF);
        rd(4'hF, 8'h85, 8'h40);
        `CHK(positiveInputSelect, 5'h1B)
        factoryOffset = 10'h14A;
        rd(4'hF, 8'h86, 8'h52);
        rd(4'hF, 8'h85, 8'h80);
        rd(4'hF, 8'hBB, 8'h00);
        rd(4'h0, 8'h86, 8'h00);
        $display("offset readout test done");
        complete_run();
    end
endmodule
`default_nettype wire
